// >>> rtl/dtm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - droop lowers frequency in proportion to load
// - flag when power-on hours reach threshold
// - flag when running hours reach threshold
// - ignore run active at power-on
// - ignore run active at fault reset
// - frequency detect one sets above level
// - hysteresis only on release, percent of level
// - frequency reached inside band of maximum
// - skip band jumps to its high edge, to its low edge when decelerating
// - frequency ramp select only motor one, no terminals
// - accel time two below switchover, else one
// - decel time one at or above switchover, else two
// - terminal jog overrides normal running
// - second frequency detect identical channel
// - two any-frequency-reached window channels
// - zero current after qualifying delay
// - overcurrent after qualifying delay
// - two any-current-reached window channels
module dtm_monitor
   import dtm_pkg::*;
#(
   parameter int TICK_COUNT = TICK_CYCLES      // cycles per 0.01 s
)
(
   input  wire logic                clock,            // 25 MHz control clock
   input  wire logic                reset,            // sync reset, high
   // ------------------------------------------------------------
   // Avalon-MM slave
   // ------------------------------------------------------------
   input  wire logic [7:0]          avs_address,      // byte address
   input  wire logic                avs_read,         // read request
   input  wire logic                avs_write,        // write request
   input  wire logic [31:0]         avs_writedata,    // write data
   input  wire logic [3:0]          avs_byteenable,   // byte lanes
   output logic [31:0]              avs_readdata,     // read data
   output logic                     avs_waitrequest,  // stall
   // ------------------------------------------------------------
   // drive core
   // ------------------------------------------------------------
   input  wire logic [FREQ_W-1:0]   ramp_freq,        // ramp generator output
   input  wire logic [FREQ_W-1:0]   set_freq,         // set frequency
   input  wire logic [CUR_W-1:0]    out_current,      // 0.1 % of rated current
   input  wire logic [15:0]         load_level,       // load, 0.1 % of rated
   input  wire logic [1:0]          ramp_dir,         // dtm_ramp_type code
   input  wire logic                motor1_active,    // motor 1 selected
   input  wire logic                terminal_ramp_sel,// terminals pick ramp times
   input  wire logic                fault_reset,      // fault reset pulse
   input  wire logic                hour_tick,        // one pulse per power-on hour
   // ------------------------------------------------------------
   // terminals (asynchronous)
   // ------------------------------------------------------------
   input  wire logic                run_pin,          // run command terminal
   input  wire logic                jog_pin,          // terminal jog command
   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   output logic [FREQ_W-1:0]        running_freq,     // after skip and droop
   output logic                     run_enable,       // qualified run
   output logic                     jog_run,          // jog running selected
   output logic                     use_time2,        // ramp group 2 selected
   output logic [11:0]              out_flags         // digital output flags
);
   import dtm_pkg::*;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [5:0] R_CTRL = 6'h00, R_DROOP = 6'h01, R_PON_TH = 6'h02, R_RUN_TH = 6'h03;
   localparam logic [5:0] R_FREQ_DETECT_LEVEL_FIRST = 6'h04, R_FDT1H = 6'h05, R_FREQ_DETECT_LEVEL_SECOND = 6'h06, R_FDT2H = 6'h07;
   localparam logic [5:0] R_BAND = 6'h08, R_FMAX = 6'h09, R_SKIPLO = 6'h0a, R_SKIPHI = 6'h0b;
   localparam logic [5:0] R_ACCSW = 6'h0c, R_DECSW = 6'h0d, R_ANYF1 = 6'h0e, R_ANYA1 = 6'h0f;
   localparam logic [5:0] R_ANYF2 = 6'h10, R_ANYA2 = 6'h11, R_ZC = 6'h12, R_ZCD = 6'h13;
   localparam logic [5:0] R_OC = 6'h14, R_OCD = 6'h15, R_ANYC1 = 6'h16, R_ANYCA1 = 6'h17;
   localparam logic [5:0] R_ANYC2 = 6'h18, R_ANYCA2 = 6'h19, R_PONH = 6'h1a, R_RUNH = 6'h1b;
   localparam logic [5:0] R_STATUS = 6'h1c;
   localparam int NREG = 28;
   localparam int B_PROT = 0, B_JOGPRI = 1, B_SKIPRAMP = 2;

   function automatic logic in_window(input logic [15:0] val, input logic [15:0] ref_v,
                                      input logic [15:0] amp);
      logic [16:0] lo;
      logic [16:0] hi;
      lo = {1'b0, ref_v} - {1'b0, amp};
      hi = {1'b0, ref_v} + {1'b0, amp};
      if (lo[16])
         lo = 17'h00000;
      in_window = ({1'b0, val} >= lo) && ({1'b0, val} <= hi);
   endfunction : in_window

   // percent (0.1 %) of a base value
   function automatic logic [15:0] pct_of(input logic [15:0] base, input logic [15:0] pct);
      logic [31:0] prod;
      prod   = base * pct;
      pct_of = 16'(prod / 32'd1000);
   endfunction : pct_of

   typedef struct packed {
      logic [NREG-1:0][15:0] regs;
      logic [1:0]            run_sync;
      logic [1:0]            jog_sync;
      logic                  run_prev;
      logic                  prot_block;
      logic                  freq_detect_level_first;
      logic                  freq_detect_level_second;
      logic                  skipping;
      logic [TICK_W-1:0]     tick_cnt;
      logic [FREQ_W-1:0]     running_freq;
      logic                  ack;
      logic [31:0]           readdata;
   } dtm_state_type;

   dtm_state_type state;
   dtm_state_type next_state;
   logic          tick;
   logic          zero_cur;
   logic          over_cur;

   assign tick = (state.tick_cnt == TICK_W'(TICK_COUNT - 1));

   // ------------------------------------------------------------
   // qualifying delays
   // ------------------------------------------------------------
   dtm_qual_timer u_zero (
      .clock     (clock),
      .reset     (reset),
      .tick      (tick),
      .condition (out_current <= state.regs[R_ZC]),
      .delay     (state.regs[R_ZCD]),
      .qualified (zero_cur)
   );

   dtm_qual_timer u_over (
      .clock     (clock),
      .reset     (reset),
      .tick      (tick),
      .condition (out_current >= state.regs[R_OC]),
      .delay     (state.regs[R_OCD]),
      .qualified (over_cur)
   );

   always_comb
   begin
      logic              run_now;
      logic [FREQ_W-1:0] droop;
      logic [FREQ_W-1:0] f;
      logic [FREQ_W-1:0] band;
      logic [5:0]        idx;
      logic [1:0]        dir;
      run_now    = 1'b0;
      droop      = '0;
      f          = '0;
      band       = '0;
      idx        = avs_address[7:2];
      dir        = 2'b00;
      next_state = state;

      // ---------------------------------------------------------
      // bus slave
      // ---------------------------------------------------------
      next_state.ack = (avs_read || avs_write) && !state.ack;
      if (avs_write && state.ack && idx < 6'(R_PONH))
      begin
         if (avs_byteenable[0])
            next_state.regs[idx][7:0] = avs_writedata[7:0];
         if (avs_byteenable[1])
            next_state.regs[idx][15:8] = avs_writedata[15:8];
      end
      if (avs_read && !state.ack)
      begin
         if (idx == R_STATUS)
            next_state.readdata = {16'h0000, 2'b00, state.prot_block, running_freq == '0, out_flags};
         else if (idx < 6'(NREG))
            next_state.readdata = {16'h0000, state.regs[idx]};
         else
            next_state.readdata = 32'h0000_0000;
      end

      next_state.tick_cnt = tick ? '0 : state.tick_cnt + TICK_W'(1);

      // ---------------------------------------------------------
      // start protection and jog
      // ---------------------------------------------------------
      next_state.run_sync = {state.run_sync[0], run_pin};
      next_state.jog_sync = {state.jog_sync[0], jog_pin};
      run_now             = state.run_sync[1];
      // run_prev masks the two cycles in which the synchroniser still fills
      next_state.run_prev = state.run_prev && (state.tick_cnt == '0);
      if (fault_reset && run_now && state.regs[R_CTRL][B_PROT])
         next_state.prot_block = 1'b1;
      else if (!run_now && !state.run_prev)
         next_state.prot_block = 1'b0;

      // ---------------------------------------------------------
      // hour counters
      // ---------------------------------------------------------
      if (hour_tick && state.regs[R_PONH] != 16'hffff)
         next_state.regs[R_PONH] = state.regs[R_PONH] + 16'h0001;
      if (hour_tick && run_enable && state.regs[R_RUNH] != 16'hffff)
         next_state.regs[R_RUNH] = state.regs[R_RUNH] + 16'h0001;

      // ---------------------------------------------------------
      // skip band and droop
      // ---------------------------------------------------------
      f = ramp_freq;
      next_state.skipping = 1'b0;
      if (state.regs[R_CTRL][B_SKIPRAMP] && state.regs[R_SKIPHI] > state.regs[R_SKIPLO]
          && ramp_freq > state.regs[R_SKIPLO] && ramp_freq < state.regs[R_SKIPHI])
      begin
         next_state.skipping = 1'b1;
         f = (dtm_ramp_type'(ramp_dir) == DTM_RAMP_DECEL) ? state.regs[R_SKIPLO]
                                                          : state.regs[R_SKIPHI];
      end
      droop = pct_of(state.regs[R_DROOP] > DROOP_MAX ? DROOP_MAX : state.regs[R_DROOP],
                     load_level > CUR_MAX ? CUR_MAX : load_level);
      next_state.running_freq = (f > droop) ? f - droop : '0;

      // ---------------------------------------------------------
      // frequency detect with release hysteresis
      // ---------------------------------------------------------
      if (state.running_freq > state.regs[R_FREQ_DETECT_LEVEL_FIRST])
         next_state.freq_detect_level_first = 1'b1;
      else if (state.running_freq < state.regs[R_FREQ_DETECT_LEVEL_FIRST] - pct_of(state.regs[R_FREQ_DETECT_LEVEL_FIRST], state.regs[R_FDT1H]))
         next_state.freq_detect_level_first = 1'b0;
      if (state.running_freq > state.regs[R_FREQ_DETECT_LEVEL_SECOND])
         next_state.freq_detect_level_second = 1'b1;
      else if (state.running_freq < state.regs[R_FREQ_DETECT_LEVEL_SECOND] - pct_of(state.regs[R_FREQ_DETECT_LEVEL_SECOND], state.regs[R_FDT2H]))
         next_state.freq_detect_level_second = 1'b0;
      dir = ramp_dir;
      band = pct_of(state.regs[R_FMAX], state.regs[R_BAND]);
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         state                  <= '0;
         state.prot_block       <= 1'b1;
         state.run_prev         <= 1'b1;
         state.regs[R_FREQ_DETECT_LEVEL_FIRST]     <= FDT_LEVEL_DEF;
         state.regs[R_FDT1H]    <= FDT_HYST_DEF;
         state.regs[R_FREQ_DETECT_LEVEL_SECOND]     <= FDT_LEVEL_DEF;
         state.regs[R_FDT2H]    <= FDT_HYST_DEF;
         state.regs[R_FMAX]     <= FDT_LEVEL_DEF;
         state.regs[R_ANYF1]    <= FDT_LEVEL_DEF;
         state.regs[R_ANYF2]    <= FDT_LEVEL_DEF;
         state.regs[R_ANYA1]    <= ANY_AMP_DEF;
         state.regs[R_ANYA2]    <= ANY_AMP_DEF;
         state.regs[R_OC]       <= OC_LEVEL_DEF;
         state.regs[R_ANYC1]    <= CUR_LEVEL_DEF;
         state.regs[R_ANYC2]    <= CUR_LEVEL_DEF;
      end
      else
         state <= next_state;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   logic run_ok;
   logic band_hit;
   logic [FREQ_W-1:0] band_w;

   assign band_w       = pct_of(state.regs[R_FMAX], state.regs[R_BAND]);
   assign band_hit     = in_window(state.running_freq, set_freq, band_w);
   // protection held from power-on until the run command is withdrawn
   assign run_ok       = !(state.regs[R_CTRL][B_PROT] && state.prot_block);
   assign run_enable   = state.run_sync[1] && run_ok;
   assign jog_run      = state.jog_sync[1] && (!run_enable || state.regs[R_CTRL][B_JOGPRI]);
   assign running_freq = state.running_freq;
   assign avs_readdata = state.readdata;
   assign avs_waitrequest = (avs_read || avs_write) && !state.ack;

   always_comb
   begin
      use_time2 = 1'b0;
      if (motor1_active && !terminal_ramp_sel)
      begin
         case (dtm_ramp_type'(ramp_dir))
            DTM_RAMP_ACCEL: use_time2 = state.running_freq < state.regs[R_ACCSW];
            DTM_RAMP_DECEL: use_time2 = state.running_freq < state.regs[R_DECSW];
            default:        use_time2 = 1'b0;
         endcase
      end
   end

   always_comb
   begin
      out_flags[0]  = state.regs[R_PONH] >= state.regs[R_PON_TH];
      out_flags[1]  = state.regs[R_RUNH] >= state.regs[R_RUN_TH];
      out_flags[2]  = state.freq_detect_level_first;
      out_flags[3]  = state.freq_detect_level_second;
      out_flags[4]  = band_hit;
      out_flags[5]  = in_window(state.running_freq, state.regs[R_ANYF1],
                                pct_of(state.regs[R_FMAX], state.regs[R_ANYA1]));
      out_flags[6]  = in_window(state.running_freq, state.regs[R_ANYF2],
                                pct_of(state.regs[R_FMAX], state.regs[R_ANYA2]));
      out_flags[7]  = zero_cur;
      out_flags[8]  = over_cur;
      out_flags[9]  = in_window(out_current, state.regs[R_ANYC1], state.regs[R_ANYCA1]);
      out_flags[10] = in_window(out_current, state.regs[R_ANYC2], state.regs[R_ANYCA2]);
      out_flags[11] = state.skipping;
   end
endmodule : dtm_monitor
`default_nettype wire

// >>> rtl/dtm_pkg.sv
package dtm_pkg;
   // ------------------------------------------------------------
   // widths and scaling
   // ------------------------------------------------------------
   localparam int FREQ_W = 16;                 // frequency in 0.01 Hz
   localparam int CUR_W  = 16;                 // current in 0.1 % of rated
   localparam int PCT_W  = 16;                 // percent in 0.1 %
   localparam int HOUR_W = 16;

   localparam logic [FREQ_W-1:0] DROOP_MAX     = 16'h03e8;  // 10.00 Hz
   localparam logic [HOUR_W-1:0] HOURS_MAX     = 16'hfde8;  // 65000 h
   localparam logic [FREQ_W-1:0] FDT_LEVEL_DEF = 16'h1388;  // 50.00 Hz
   localparam logic [PCT_W-1:0]  FDT_HYST_DEF  = 16'h0032;  // 5.0 %
   localparam logic [PCT_W-1:0]  PCT_FULL      = 16'h03e8;  // 100.0 %
   localparam logic [PCT_W-1:0]  ANY_AMP_DEF   = 16'h0000;  // 0.0 %
   localparam logic [CUR_W-1:0]  OC_LEVEL_DEF  = 16'h07d0;  // 200.0 %
   localparam logic [CUR_W-1:0]  CUR_LEVEL_DEF = 16'h03e8;  // 100.0 %
   localparam logic [CUR_W-1:0]  CUR_MAX       = 16'h0bb8;  // 300.0 %
   localparam logic [15:0]       LOAD_FULL     = 16'h03e8;  // load at rated

   // ------------------------------------------------------------
   // qualifying delay timing
   // ------------------------------------------------------------
   localparam int CLOCK_HZ     = 25_000_000;
   localparam int DELAY_TICK_US = 10_000;     // delay unit 0.01 s
   localparam int TICK_CYCLES = (CLOCK_HZ / 1_000_000) * DELAY_TICK_US;
   localparam int TICK_W      = 18;
   localparam logic [15:0] OC_DELAY_MAX = 16'hea60;  // 600.00 s

   typedef enum logic [1:0] {
      DTM_RAMP_HOLD,
      DTM_RAMP_ACCEL,
      DTM_RAMP_DECEL
   } dtm_ramp_type;
endpackage : dtm_pkg

// >>> rtl/dtm_qual_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dtm_qual_timer
   import dtm_pkg::*;
(
   input  wire logic        clock,      // control clock
   input  wire logic        reset,      // sync reset
   input  wire logic        tick,       // 0.01 s time base
   input  wire logic        condition,  // raw detect condition
   input  wire logic [15:0] delay,      // delay in 0.01 s
   output logic             qualified   // condition held past delay
);
   typedef struct packed {
      logic [15:0] count;
      logic        qualified;
   } dtm_qual_type;

   dtm_qual_type state;
   dtm_qual_type next_state;

   always_comb
   begin
      next_state = state;
      if (!condition)
      begin
         next_state.count     = 16'h0000;
         next_state.qualified = 1'b0;
      end
      else if (state.count > delay || (delay == 16'h0000))
      begin
         next_state.qualified = 1'b1;
      end
      else if (tick)
      begin
         next_state.count = state.count + 16'h0001;
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
         state <= '0;
      else
         state <= next_state;
   end

   assign qualified = state.qualified;
endmodule : dtm_qual_timer
`default_nettype wire

// >>> test/dtm_monitor_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dtm_monitor_chk
   import dtm_pkg::*;
#(
   parameter int TICK_COUNT = TICK_CYCLES  // cycles per tick
)
(
   input wire logic        clock,             // clock
   input wire logic        reset,             // sync reset
   input wire logic [7:0]  avs_address,       // bus address
   input wire logic        avs_read,          // bus read
   input wire logic        avs_write,         // bus write
   input wire logic [31:0] avs_readdata,      // bus data
   input wire logic        avs_waitrequest,   // bus stall
   input wire logic        motor1_active,     // motor 1
   input wire logic        terminal_ramp_sel, // terminal ramp pick
   input wire logic        run_pin,           // run terminal
   input wire logic        jog_pin,           // jog terminal
   input wire logic        run_enable,        // qualified run
   input wire logic        jog_run,           // jog running
   input wire logic        use_time2,         // ramp group 2
   input wire logic [11:0] out_flags          // output flags
);
   // ------------------------------------------------------------
   // bus and terminal relations
   // ------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   wire req = avs_read || avs_write;

   chk_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
      else $error("request accepted in its first cycle");
   chk_wait_short: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("request stalled beyond one cycle");
   chk_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
      else $error("upper half of read data not zero");
   chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[7:2] > 6'h1c
                                       |-> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   chk_data_stands: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   chk_run_release: assert property (!run_pin ##1 !run_pin ##1 !run_pin |-> !run_enable)
      else $error("run enabled without run terminal");
   chk_jog_release: assert property (!jog_pin ##1 !jog_pin ##1 !jog_pin |-> !jog_run)
      else $error("jog running without jog terminal");
   chk_ramp_select: assert property (!motor1_active || terminal_ramp_sel |-> !use_time2)
      else $error("frequency ramp select while not allowed");

   cover property (avs_write && !avs_waitrequest);
   cover property ($rose(out_flags[7]));
   cover property ($rose(jog_run));
endmodule : dtm_monitor_chk

bind dtm_monitor dtm_monitor_chk #(.TICK_COUNT(TICK_COUNT)) chk_u (
   .clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .motor1_active(motor1_active), .terminal_ramp_sel(terminal_ramp_sel), .run_pin(run_pin),
   .jog_pin(jog_pin), .run_enable(run_enable), .jog_run(jog_run), .use_time2(use_time2),
   .out_flags(out_flags)
);
`default_nettype wire

// >>> test/dtm_monitor_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dtm_monitor_bench;
   import dtm_pkg::*;
   // ------------------------------------------------------------
   // signals and tables
   // ------------------------------------------------------------
   logic              clock = 1'h0, reset = 1'h1, avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest;
   logic [7:0]        avs_address = 8'h00;
   logic [31:0]       avs_writedata = 32'h0000_0000, avs_readdata, rdata;
   logic [FREQ_W-1:0] ramp_freq = 16'h0000, set_freq = 16'h03b6, running_freq;
   logic [CUR_W-1:0]  out_current = 16'h03e8;
   logic [15:0]       load_level = 16'h0000;
   logic [1:0]        ramp_dir = 2'h0;
   logic              motor1_active = 1'h0, terminal_ramp_sel = 1'h0, fault_reset = 1'h0, hour_tick = 1'h0;
   logic              run_pin = 1'h0, jog_pin = 1'h0, run_enable, jog_run, use_time2;
   logic [11:0]       out_flags;
   int                miscompares = 0, n_checks = 0;
   logic [5:0]        def_idx [8] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h0e, 6'h14, 6'h16, 6'h19};
   logic [15:0]       def_val [8] = '{FDT_LEVEL_DEF, FDT_HYST_DEF, FDT_LEVEL_DEF, FDT_HYST_DEF,
                                      FDT_LEVEL_DEF, OC_LEVEL_DEF, CUR_LEVEL_DEF, ANY_AMP_DEF};
   logic [15:0]       fq [5] = '{16'h03e9, 16'h03b6, 16'h0383, 16'h03b6, 16'h03e9};
   logic              f1 [5] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1};
   logic              f2 [5] = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h1};
   logic [15:0]       rq [4] = '{16'h01f4, 16'h05dc, 16'h05dc, 16'h01f4};
   logic [1:0]        rd [4] = '{2'h1, 2'h1, 2'h2, 2'h2};
   logic              ut [4] = '{1'h1, 1'h0, 1'h0, 1'h1};
   logic [15:0]       cq [4] = '{16'h03e8, 16'h041a, 16'h041b, 16'h03b6};
   logic              c1 [4] = '{1'h1, 1'h1, 1'h0, 1'h1};
   logic              c2 [4] = '{1'h1, 1'h0, 1'h0, 1'h0};

   dtm_monitor #(.TICK_COUNT(10)) dut_u (
      .clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ramp_freq(ramp_freq),
      .set_freq(set_freq), .out_current(out_current), .load_level(load_level), .ramp_dir(ramp_dir),
      .motor1_active(motor1_active), .terminal_ramp_sel(terminal_ramp_sel), .fault_reset(fault_reset),
      .hour_tick(hour_tick), .run_pin(run_pin), .jog_pin(jog_pin), .running_freq(running_freq),
      .run_enable(run_enable), .jog_run(jog_run), .use_time2(use_time2), .out_flags(out_flags)
   );

   initial
      forever #20 clock = ~clock;

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want)
      begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic bus(input logic wr_en, input logic [5:0] idx, input logic [15:0] data);
      @(posedge clock);
      avs_address   <= {idx, 2'h0};
      avs_write     <= wr_en;
      avs_read      <= !wr_en;
      avs_writedata <= {16'h0000, data};
      do
         @(posedge clock);
      while (avs_waitrequest !== 1'h0);
      rdata = avs_readdata;
      avs_write <= 1'h0;
      avs_read  <= 1'h0;
   endtask : bus

   task automatic wr(input logic [5:0] idx, input logic [15:0] data);
      bus(1'h1, idx, data);
   endtask : wr

   task automatic rdchk(input logic [5:0] idx, input logic [15:0] want);
      bus(1'h0, idx, 16'h0000);
      check(rdata, {16'h0000, want});
   endtask : rdchk

   // wait n edges, then sample once updates have landed
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : settle

   task automatic complete_run();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clock);
      reset <= 1'h0;
      settle(3);
      check(out_flags[0], 1'h1);
      foreach (def_idx[i])
         rdchk(def_idx[i], def_val[i]);
      rdchk(6'h1d, 16'h0000);
      wr(6'h1a, 16'h0005);
      rdchk(6'h1a, 16'h0000);
      $display("test register defaults done");
      wr(6'h04, 16'h03e8);
      wr(6'h05, 16'h0064);
      wr(6'h06, 16'h03e8);
      wr(6'h07, 16'h0000);
      wr(6'h0e, 16'h03b6);
      wr(6'h10, 16'h03e9);
      foreach (fq[i])
      begin
         @(posedge clock);
         ramp_freq <= fq[i];
         settle(4);
         check(out_flags[2], f1[i]);
         check(out_flags[3], f2[i]);
         check(out_flags[4], fq[i] == set_freq);
         check(out_flags[5], fq[i] == 16'h03b6);
         check(out_flags[6], fq[i] == 16'h03e9);
      end
      $display("test frequency detect done");
      wr(6'h0c, 16'h03e8);
      wr(6'h0d, 16'h03e8);
      foreach (rq[i])
      begin
         @(posedge clock);
         motor1_active <= 1'h1;
         ramp_freq     <= rq[i];
         ramp_dir      <= rd[i];
         settle(4);
         check(use_time2, ut[i]);
      end
      @(posedge clock);
      terminal_ramp_sel <= 1'h1;
      settle(4);
      check(use_time2, 1'h0);
      $display("test ramp select done");
      wr(6'h01, DROOP_MAX);
      @(posedge clock);
      terminal_ramp_sel <= 1'h0;
      ramp_dir          <= DTM_RAMP_HOLD;
      ramp_freq         <= 16'h0bb8;
      load_level        <= 16'h01f4;
      settle(4);
      check(running_freq, 16'h09c4);
      wr(6'h01, 16'h0000);
      wr(6'h00, 16'h0004);
      wr(6'h0a, 16'h07d0);
      wr(6'h0b, 16'h0898);
      @(posedge clock);
      ramp_dir  <= DTM_RAMP_ACCEL;
      ramp_freq <= 16'h0834;
      settle(4);
      check(running_freq, 16'h0898);
      check(out_flags[11], 1'h1);
      $display("test droop and skip done");
      wr(6'h12, 16'h0032);
      wr(6'h13, 16'h0003);
      wr(6'h17, 16'h0032);
      @(posedge clock);
      out_current <= 16'h0028;
      settle(20);
      @(posedge clock);
      out_current <= 16'h0064;
      @(posedge clock);
      out_current <= 16'h0028;
      settle(30);
      check(out_flags[7], 1'h0);
      settle(30);
      check(out_flags[7], 1'h1);
      foreach (cq[i])
      begin
         @(posedge clock);
         out_current <= cq[i];
         settle(4);
         check(out_flags[9], c1[i]);
         check(out_flags[10], c2[i]);
      end
      @(posedge clock);
      out_current <= OC_LEVEL_DEF;
      settle(30);
      check(out_flags[8], 1'h1);
      @(posedge clock);
      out_current <= 16'h07cf;
      settle(4);
      check(out_flags[8], 1'h0);
      $display("test current detect done");
      wr(6'h00, 16'h0003);
      @(posedge clock);
      run_pin <= 1'h1;
      settle(6);
      check(run_enable, 1'h1);
      @(posedge clock);
      fault_reset <= 1'h1;
      @(posedge clock);
      fault_reset <= 1'h0;
      settle(6);
      check(run_enable, 1'h0);
      @(posedge clock);
      run_pin <= 1'h0;
      settle(6);
      @(posedge clock);
      run_pin <= 1'h1;
      jog_pin <= 1'h1;
      settle(6);
      check(run_enable, 1'h1);
      check(jog_run, 1'h1);
      $display("test protection and jog done");
      wr(6'h02, 16'h0002);
      wr(6'h03, 16'h0002);
      settle(2);
      check(out_flags[1:0], 2'h0);
      repeat (2)
      begin
         @(posedge clock);
         hour_tick <= 1'h1;
         @(posedge clock);
         hour_tick <= 1'h0;
      end
      settle(2);
      check(out_flags[1:0], 2'h3);
      rdchk(6'h1a, 16'h0002);
      $display("test hours done");
      @(posedge clock);
      reset <= 1'h1;
      settle(3);
      @(posedge clock);
      reset <= 1'h0;
      wr(6'h00, 16'h0001);
      settle(4);
      check(run_enable, 1'h0);
      @(posedge clock);
      run_pin <= 1'h0;
      settle(6);
      @(posedge clock);
      run_pin <= 1'h1;
      settle(6);
      check(run_enable, 1'h1);
      check(jog_run, 1'h0);
      $display("test restart protection done");
      complete_run();
   end

   initial
   begin
      repeat (5000) @(posedge clock);
      miscompares++;
      complete_run();
   end
endmodule : dtm_monitor_bench
`default_nettype wire
